// [core/pst_consts.vh]
// Constants shared by the single-phase bus target.
`ifndef PST_CONSTS_VH
`define PST_CONSTS_VH

// ----------------------------------------
// Bus commands on the command/byte-enable lines.
// ----------------------------------------
`define PST_CMD_IO_RD 4'h2
`define PST_CMD_IO_WR 4'h3
`define PST_CMD_MEM_RD 4'h6
`define PST_CMD_MEM_WR 4'h7
`define PST_CMD_CFG_RD 4'ha
`define PST_CMD_CFG_WR 4'hb
`define PST_CMD_MEM_RDM 4'hc
`define PST_CMD_MEM_RDL 4'he
`define PST_CMD_MEM_WRI 4'hf

// ----------------------------------------
// Address space codes on the access port.
// ----------------------------------------
`define PST_SP_NONE 2'h0
`define PST_SP_IO 2'h1
`define PST_SP_MEM 2'h2
`define PST_SP_CFG 2'h3

// ----------------------------------------
// Field positions and reset values.
// ----------------------------------------
`define PST_ALIGN_MSB 1
`define PST_ALIGN_LSB 0
`define PST_RST_BUS 32'h0000_0000
`define PST_RST_NIB 4'hf
`define PST_RST_HIGH 1'b1
`define PST_RST_LOW 1'b0
`define PST_STATE_W 9

`endif

// [core/pst_parity.v]
// Even parity generator over a bundle of lines.
`timescale 1ns/1ps
`default_nettype none

module pst_parity #(
   parameter WIDTH = 36
) (
   // Lines covered.
   input wire [WIDTH-1:0] bits_i,
   // Bit that makes the count of ones even.
   output wire par_o
);

   // ----------------------------------------
   // Parity reduction.
   // ----------------------------------------
   assign par_o = ^bits_i;

endmodule // pst_parity

`default_nettype wire

// [core/pst_target.v]
// Single-data-phase target for a 32-bit synchronous expansion bus.
//
// Functional notes
// R1: Device is target only, never initiates.
// R2: Master opens with FRAME, address, command.
// R3: Addressed device asserts DEVSEL, TRDY with data.
// R4: Word moves when IRDY and TRDY both low.
// R5: Byte enables select doubleword or word.
// R6: Only first data phase; bursts retried.
// R7: FRAME still low: assert STOP, no data.
// R8: Master restarts remaining data in new transaction.
// R9: Write data may follow address immediately.
// R10: Finished when all four controls deasserted.
// R11: IDSEL in address phase selects configuration.
// R12: Target abort: DEVSEL high with STOP low.
// R13: One DEVSEL clock without TRDY before abort.
// R14: Address parity error aborts, raises system error.
// R15: Byte enables must match low address bits.
// R16: Fast back-to-back transactions are accepted.
// R17: Parity keeps ones count even on 37 lines.
// R18: PAR one clock after phase, error after.
// R19: Data parity error raises parity error indication.
// R20: Undecoded transactions leave DEVSEL deasserted.
`timescale 1ns/1ps
`default_nettype none
`include "pst_consts.vh"

module pst_target #(
   parameter [31:0] IO_BASE = 32'h0000_0300,
   parameter [31:0] IO_MASK = 32'hffff_ffe0,
   parameter [31:0] MEM_BASE = 32'h000d_0000,
   parameter [31:0] MEM_MASK = 32'hffff_0000
) (
   // Clock and reset.
   input wire clk,
   input wire rst_n,
   // Bus inputs.
   input wire frame_n_i,
   input wire irdy_n_i,
   input wire idsel_i,
   input wire [31:0] ad_i,
   input wire [3:0] cbe_n_i,
   input wire par_i,
   // Bus outputs and enables.
   output wire [31:0] ad_o,
   output wire ad_oe_n,
   output wire par_o,
   output wire par_oe_n,
   output wire devsel_n_o,
   output wire trdy_n_o,
   output wire stop_n_o,
   output wire tgt_oe_n,
   // Access port toward the register file.
   output wire acc_rd_o,
   output wire acc_wr_o,
   output wire [1:0] acc_space_o,
   output wire [31:0] acc_addr_o,
   output wire [3:0] acc_be_n_o,
   output wire [31:0] acc_wdata_o,
   input wire [31:0] acc_rdata_i,
   // Internal error indications.
   output wire serr_o,
   output wire perr_o
);

   // ----------------------------------------
   // States, one-hot.
   // ----------------------------------------
   localparam S_IDLE = 0;
   localparam S_CHK = 1;
   localparam S_FETCH = 2;
   localparam S_DATA = 3;
   localparam S_STOP = 4;
   localparam S_ABTW = 5;
   localparam S_ABT = 6;
   localparam S_TURN = 7;
   localparam S_SKIP = 8;
   localparam [8:0] ST_IDLE = 9'h001;
   localparam [8:0] ST_CHK = 9'h002;
   localparam [8:0] ST_FETCH = 9'h004;
   localparam [8:0] ST_DATA = 9'h008;
   localparam [8:0] ST_STOP = 9'h010;
   localparam [8:0] ST_ABTW = 9'h020;
   localparam [8:0] ST_ABT = 9'h040;
   localparam [8:0] ST_TURN = 9'h080;
   localparam [8:0] ST_SKIP = 9'h100;

   // ----------------------------------------
   // Decoding functions.
   // ----------------------------------------
   function [1:0] cmd_space;
      input [3:0] cmd;
      input sel;
      begin
         case (cmd)
            `PST_CMD_IO_RD, `PST_CMD_IO_WR: cmd_space = `PST_SP_IO;
            `PST_CMD_MEM_RD, `PST_CMD_MEM_WR, `PST_CMD_MEM_RDM,
            `PST_CMD_MEM_RDL, `PST_CMD_MEM_WRI: cmd_space = `PST_SP_MEM;
            `PST_CMD_CFG_RD, `PST_CMD_CFG_WR: cmd_space = sel ? `PST_SP_CFG : `PST_SP_NONE;
            default: cmd_space = `PST_SP_NONE;
         endcase
      end
   endfunction

   function cmd_write;
      input [3:0] cmd;
      begin
         cmd_write = (cmd == `PST_CMD_IO_WR) || (cmd == `PST_CMD_MEM_WR) ||
                     (cmd == `PST_CMD_CFG_WR) || (cmd == `PST_CMD_MEM_WRI);
      end
   endfunction

   // Lowest enabled byte must be the one the address points to; low address bits of 3 are always rejected.
   function be_aligned;
      input [1:0] low;
      input [3:0] be_n;
      begin
         case (low)
            2'h0: be_aligned = ~be_n[0];
            2'h1: be_aligned = be_n[0] & ~be_n[1];
            2'h2: be_aligned = be_n[0] & be_n[1] & ~be_n[2];
            default: be_aligned = 1'b0;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Registers.
   // ----------------------------------------
   reg [8:0] state_q;
   reg [8:0] state_d;
   reg frame_last_q;
   reg [31:0] addr_q;
   reg [3:0] cmd_q;
   reg idsel_q;
   reg [3:0] be_q;
   reg [31:0] rdata_q;
   reg [31:0] wdata_q;
   reg [3:0] wbe_q;
   reg wr_q;
   reg wchk_q;
   reg par_q;
   reg par_oe_n_q;
   reg serr_q;
   reg perr_q;

   wire addr_phase;
   wire [1:0] space;
   wire is_write;
   wire hit;
   wire aligned;
   wire addr_par;
   wire data_par;
   wire out_par;
   wire xfer;
   wire addr_par_err;

   // ----------------------------------------
   // Address phase and decode.
   // ----------------------------------------
   // A falling FRAME after a high one opens a transaction; also taken in
   // the turnaround and skip states so back-to-back cycles are not lost.
   assign addr_phase = ~frame_n_i & frame_last_q &
                       (state_q[S_IDLE] | state_q[S_TURN] | state_q[S_SKIP]); // R2 R16
   assign space = cmd_space(cmd_q, idsel_q); // R11
   assign is_write = cmd_write(cmd_q);
   assign hit = (space == `PST_SP_IO) ? ((addr_q & IO_MASK) == IO_BASE) :
                (space == `PST_SP_MEM) ? ((addr_q & MEM_MASK) == MEM_BASE) :
                (space == `PST_SP_CFG); // R20
   assign aligned = be_aligned(addr_q[`PST_ALIGN_MSB:`PST_ALIGN_LSB], cbe_n_i); // R15 R5
   assign addr_par_err = addr_par != par_i; // R14
   assign xfer = state_q[S_DATA] & ~irdy_n_i; // R4

   // ----------------------------------------
   // Parity generators and checkers.
   // ----------------------------------------
   pst_parity #(.WIDTH(36)) u_addr_par (
      .bits_i({addr_q, cmd_q}),
      .par_o(addr_par)
   );

   pst_parity #(.WIDTH(36)) u_data_par (
      .bits_i({wdata_q, wbe_q}),
      .par_o(data_par)
   );

   pst_parity #(.WIDTH(36)) u_out_par (
      .bits_i({rdata_q, cbe_n_i}),
      .par_o(out_par)
   );

   // ----------------------------------------
   // Next state.
   // ----------------------------------------
   always @* begin
      state_d = state_q;
      case (1'b1)
         state_q[S_IDLE], state_q[S_TURN], state_q[S_SKIP]: begin
            if (addr_phase) begin
               state_d = ST_CHK;
            end else if (state_q[S_SKIP] & ~(frame_n_i & irdy_n_i)) begin
               state_d = ST_SKIP;
            end else begin
               state_d = ST_IDLE; // R10
            end
         end
         state_q[S_CHK]: begin
            if (!hit) begin
               state_d = ST_SKIP; // R20
            end else if (addr_par_err || !aligned) begin
               state_d = ST_ABTW; // R14 R15
            end else if (is_write) begin
               state_d = ST_DATA; // R9
            end else begin
               state_d = ST_FETCH;
            end
         end
         state_q[S_FETCH]: begin
            state_d = ST_DATA;
         end
         state_q[S_DATA]: begin
            if (xfer && !frame_n_i) begin
               state_d = ST_STOP; // R6 R7
            end else if (xfer) begin
               state_d = ST_TURN;
            end
         end
         state_q[S_STOP]: begin
            if (frame_n_i) begin
               state_d = ST_TURN; // R7
            end
         end
         state_q[S_ABTW]: begin
            state_d = ST_ABT; // R13
         end
         state_q[S_ABT]: begin
            if (frame_n_i) begin
               state_d = ST_TURN; // R12
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // State and address capture.
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         frame_last_q <= `PST_RST_HIGH;
         addr_q <= `PST_RST_BUS;
         cmd_q <= `PST_RST_NIB;
         idsel_q <= `PST_RST_LOW;
         be_q <= `PST_RST_NIB;
      end else begin
         state_q <= state_d;
         frame_last_q <= frame_n_i;
         if (addr_phase) begin
            addr_q <= ad_i; // R2
            cmd_q <= cbe_n_i;
            idsel_q <= idsel_i; // R11
         end
         if (state_q[S_CHK]) begin
            be_q <= cbe_n_i; // R5
         end
      end
   end

   // ----------------------------------------
   // Data movement.
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= `PST_RST_BUS;
         wdata_q <= `PST_RST_BUS;
         wbe_q <= `PST_RST_NIB;
         wr_q <= `PST_RST_LOW;
         wchk_q <= `PST_RST_LOW;
      end else begin
         if (state_q[S_FETCH]) begin
            rdata_q <= acc_rdata_i; // R3
         end
         wr_q <= xfer & is_write; // R4
         wchk_q <= xfer & is_write;
         if (xfer) begin
            wdata_q <= ad_i;
            wbe_q <= cbe_n_i;
         end
      end
   end

   // ----------------------------------------
   // Parity output and error indications.
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         par_q <= `PST_RST_LOW;
         par_oe_n_q <= `PST_RST_HIGH;
         serr_q <= `PST_RST_LOW;
         perr_q <= `PST_RST_LOW;
      end else begin
         par_q <= out_par; // R17 R18
         par_oe_n_q <= ad_oe_n; // R18
         serr_q <= state_q[S_CHK] & hit & addr_par_err; // R14
         perr_q <= wchk_q & (data_par != par_i); // R19 R18
      end
   end

   // ----------------------------------------
   // Bus drive.
   // ----------------------------------------
   // Only target signals are driven; there is no request or address
   // drive, so the block never opens a transaction itself.
   assign ad_o = rdata_q; // R3 R1
   assign ad_oe_n = ~(state_q[S_DATA] & ~is_write);
   assign par_o = par_q;
   assign par_oe_n = par_oe_n_q;
   assign devsel_n_o = ~(state_q[S_FETCH] | state_q[S_DATA] | state_q[S_STOP] |
                         state_q[S_ABTW]); // R3 R12 R13
   assign trdy_n_o = ~state_q[S_DATA]; // R3 R7 R13
   assign stop_n_o = ~(state_q[S_STOP] | state_q[S_ABT]); // R7 R12
   assign tgt_oe_n = ~(state_q[S_FETCH] | state_q[S_DATA] | state_q[S_STOP] |
                       state_q[S_ABTW] | state_q[S_ABT] | state_q[S_TURN]); // R10 R20

   // ----------------------------------------
   // Access port.
   // ----------------------------------------
   assign acc_rd_o = state_q[S_FETCH];
   assign acc_wr_o = wr_q;
   assign acc_space_o = space;
   assign acc_addr_o = addr_q;
   assign acc_be_n_o = wr_q ? wbe_q : be_q;
   assign acc_wdata_o = wdata_q;
   assign serr_o = serr_q;
   assign perr_o = perr_q;

endmodule // pst_target

`default_nettype wire

// [sim/pci_single_phase_target_tb.sv]
// Self-checking bench for the single-phase target.
`timescale 1ns/1ps
`default_nettype none
module pci_single_phase_target_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] rdata_q = 32'h0;
   int err_total = 0, check_count = 0, serr_e = 0, perr_e = 0;
   integer serr_n = 0, perr_n = 0;
   logic [69:0] exp_q[$];
   logic [37:0] exp_rd[$];
   logic [3:0] cmd_t [9] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'ha, 4'hb, 4'hc, 4'he, 4'hf};
   logic [3:0] be_t [4] = '{4'h0, 4'hc, 4'h3, 4'h9};
   wire frame_n, irdy_n, idsel, m_par, par_o, par_oe_n, ad_oe_n, devsel_n_o, trdy_n_o, stop_n_o, tgt_oe_n;
   wire acc_rd_o, acc_wr_o, serr_o, perr_o;
   wire [31:0] m_ad, ad_o, acc_wdata_o, acc_addr_o;
   wire [3:0] cbe_n, acc_be_n_o;
   wire [1:0] acc_space_o;
   wire [31:0] ad_w = ad_oe_n ? m_ad : ad_o;
   wire par_w = par_oe_n ? m_par : par_o;
   always #5 clk = ~clk;
   pst_target pst_target_i (.clk(clk), .rst_n(rst_n), .frame_n_i(frame_n), .irdy_n_i(irdy_n), .idsel_i(idsel),
      .ad_i(ad_w), .cbe_n_i(cbe_n), .par_i(par_w), .ad_o(ad_o), .ad_oe_n(ad_oe_n), .par_o(par_o),
      .par_oe_n(par_oe_n), .devsel_n_o(devsel_n_o), .trdy_n_o(trdy_n_o), .stop_n_o(stop_n_o),
      .tgt_oe_n(tgt_oe_n), .acc_rd_o(acc_rd_o), .acc_wr_o(acc_wr_o), .acc_space_o(acc_space_o),
      .acc_addr_o(acc_addr_o),
      .acc_be_n_o(acc_be_n_o), .acc_wdata_o(acc_wdata_o), .acc_rdata_i(rdata_q), .serr_o(serr_o),
      .perr_o(perr_o));
   pst_master pst_master_i (.clk(clk), .ad_bus(ad_w), .devsel_n(tgt_oe_n | devsel_n_o),
      .trdy_n(tgt_oe_n | trdy_n_o), .stop_n(tgt_oe_n | stop_n_o), .frame_n(frame_n), .irdy_n(irdy_n),
      .idsel(idsel), .ad(m_ad), .cbe_n(cbe_n), .par(m_par));
   task automatic check(input logic [69:0] got, input logic [69:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      if (rst_n) begin
         serr_n += serr_o;
         perr_n += perr_o;
      end
      if (acc_wr_o === 1'b1) check({acc_space_o, acc_be_n_o, acc_addr_o, acc_wdata_o}, exp_q.pop_front());
      if (acc_rd_o === 1'b1) check({acc_space_o, acc_be_n_o, acc_addr_o}, exp_rd.pop_front());
   end
   initial begin
      #100000;
      err_total++;
      stop_test();
   end
   initial begin
      logic [3:0] c, be;
      logic [31:0] a, rd, wd;
      logic [1:0] st, st_e, sp;
      logic bu, bpa, bpd, id, hit, mis;
      void'($urandom(81));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 300; i++) begin
         c = cmd_t[$urandom_range(8)];
         case ($urandom_range(2))
            0: a = 32'h300 | $urandom_range(31);
            1: a = 32'hd0000 | $urandom_range(65535);
            default: a = $urandom;
         endcase
         be = be_t[$urandom_range(3)];
         wd = $urandom;
         bu = c[2] & ($urandom_range(3) == 0);
         bpa = $urandom_range(15) == 0;
         bpd = !bu & ($urandom_range(7) == 0);
         id = $urandom_range(7) != 0;
         hit = c[3:1] == 3'h5 ? id : c[3:1] == 3'h1 ? a[31:5] == 27'h18 : c[2] & (a[31:16] == 16'hd);
         mis = a[1:0] == 2'h3 || (be & ((4'h2 << a[1:0]) - 4'h1)) != ((4'h1 << a[1:0]) - 4'h1);
         st_e = !hit ? 2'h2 : (bpa | mis) ? 2'h1 : {bu, bu};
         serr_e += hit & bpa;
         perr_e += c[0] & bpd & (st_e == 2'h0);
         sp = c[3:1] == 3'h5 ? 2'h3 : c[2] ? 2'h2 : 2'h1;
         if (c[0] && st_e[1] == st_e[0])
            exp_q.push_back({sp, be, a, wd});
         if (!c[0] && st_e[1] == st_e[0])
            exp_rd.push_back({sp, be, a});
         rdata_q <= $urandom;
         pst_master_i.xfer(c, be, a, wd, id, bu, bpa, bpd, st, rd);
         check(st, st_e);
         if (!c[0] && st_e[1] == st_e[0]) check(rd, rdata_q);
         if (st_e != 2'h0 || !c[0] || $urandom_range(1)) pst_master_i.rel();
      end
      repeat (4) @(posedge clk);
      check(exp_q.size(), 0);
      check(exp_rd.size(), 0);
      check(serr_n, serr_e);
      check(perr_n, perr_e);
      stop_test();
   end
endmodule // pci_single_phase_target_tb
`default_nettype wire

// [sim/pst_master.sv]
// Bus master model issuing single transactions.
`timescale 1ns/1ps
`default_nettype none
module pst_master (
   // Clock and target answers.
   input wire logic clk,
   input wire logic [31:0] ad_bus,
   input wire logic devsel_n,
   input wire logic trdy_n,
   input wire logic stop_n,
   // Master lines.
   output var logic frame_n,
   output var logic irdy_n,
   output var logic idsel,
   output var logic [31:0] ad,
   output var logic [3:0] cbe_n,
   output var logic par
);
   initial begin
      {frame_n, irdy_n, idsel, ad, cbe_n, par} = {2'h3, 33'h0, 5'h1e};
   end
   // Released lines show a changed value.
   task automatic rel();
      ad <= ~ad;
      cbe_n <= ~cbe_n;
      @(posedge clk);
      par <= ~par;
   endtask
   task automatic xfer(input logic [3:0] c, input logic [3:0] be, input logic [31:0] a, input logic [31:0] wd,
         input logic id, input logic bu, input logic bpa, input logic bpd, output logic [1:0] st,
         output logic [31:0] rd);
      st = 2'h2;
      rd = 32'h0;
      frame_n <= 1'b0;
      ad <= a;
      cbe_n <= c;
      idsel <= id & (c[3:1] == 3'h5);
      @(posedge clk);
      frame_n <= ~bu;
      irdy_n <= 1'b0;
      idsel <= 1'b0;
      ad <= c[0] ? wd : ~a;
      cbe_n <= be;
      par <= ^{a, c} ^ bpa;
      for (int n = 0; n < 8 && st == 2'h2; n++) begin
         @(posedge clk);
         if (!stop_n && devsel_n) st = 2'h1;
         else if (!trdy_n) begin
            st = 2'h0;
            rd = ad_bus;
         end else par <= ~par;
      end
      if (st == 2'h0) begin
         par <= c[0] ? ^{wd, be} ^ bpd : ~par;
         if (bu) begin
            for (int n = 0; n < 4 && stop_n; n++) @(posedge clk);
            if (!stop_n && trdy_n) st = 2'h3;
            frame_n <= 1'b1;
            @(posedge clk);
         end
      end else frame_n <= 1'b1;
      irdy_n <= 1'b1;
   endtask
endmodule // pst_master
`default_nettype wire

// [sim/pst_target_asserts.sv]
// Concurrent checks on the target ports.
`timescale 1ns/1ps
`default_nettype none
module pst_target_asserts (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Watched ports.
   input wire logic irdy_n_i,
   input wire logic [3:0] cbe_n_i,
   input wire logic [31:0] ad_o,
   input wire logic ad_oe_n,
   input wire logic par_o,
   input wire logic par_oe_n,
   input wire logic devsel_n_o,
   input wire logic trdy_n_o,
   input wire logic stop_n_o,
   input wire logic tgt_oe_n,
   input wire logic acc_wr_o,
   input wire logic serr_o,
   input wire logic perr_o
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_wait; !devsel_n_o && trdy_n_o && stop_n_o; endsequence
   sequence s_abt; devsel_n_o && !stop_n_o; endsequence
   a_abort_prior: assert property ($fell(stop_n_o) && devsel_n_o |-> $past(!devsel_n_o && trdy_n_o))
      else $error("abort without wait cycle");
   a_abort_drop: assert property (s_wait ##1 !stop_n_o |-> devsel_n_o)
      else $error("abort kept select");
   a_stop_no_data: assert property (!stop_n_o |-> trdy_n_o)
      else $error("ready with stop");
   a_single_phase: assert property (!trdy_n_o && !irdy_n_i |=> trdy_n_o)
      else $error("second data phase");
   a_read_drive: assert property (!ad_oe_n |-> !trdy_n_o && !devsel_n_o && !tgt_oe_n)
      else $error("data without ready");
   a_par_lag: assert property (!ad_oe_n |=> !par_oe_n && par_o == ^{$past(ad_o), $past(cbe_n_i)})
      else $error("bad read parity");
   a_write_xfer: assert property (acc_wr_o |-> $past(!trdy_n_o && !irdy_n_i))
      else $error("write without transfer");
   a_serr_abort: assert property (serr_o |-> ##[0:3] s_abt)
      else $error("system error without abort");
   a_perr_write: assert property (perr_o |-> $past(acc_wr_o))
      else $error("parity error without write");
endmodule // pst_target_asserts
bind pst_target pst_target_asserts pst_target_asserts_i (.clk(clk), .rst_n(rst_n), .irdy_n_i(irdy_n_i),
   .cbe_n_i(cbe_n_i), .ad_o(ad_o), .ad_oe_n(ad_oe_n), .par_o(par_o), .par_oe_n(par_oe_n),
   .devsel_n_o(devsel_n_o), .trdy_n_o(trdy_n_o), .stop_n_o(stop_n_o), .tgt_oe_n(tgt_oe_n),
   .acc_wr_o(acc_wr_o), .serr_o(serr_o), .perr_o(perr_o));
`default_nettype wire
